// file: hw/pgro_pkg.sv
// Shared constants for the port block with real-time output halves
package pgro_pkg;

  // Port geometry
  localparam int PORT_W = 8; // Pins in the port
  localparam int HALF_W = 4; // Pins in one real-time half
  localparam int ADDR_W = 8; // Byte address width on the bus
  localparam int DATA_W = 32; // Bus data width

  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFS_PORT_DATA = 8'h00; // Output latch and pin view
  localparam logic [7:0] OFS_DIRECTION = 8'h04; // Direction, 1 means input
  localparam logic [7:0] OFS_RT_CTRL = 8'h08; // Real-time half enables
  localparam logic [7:0] OFS_LOW_BUF = 8'h0c; // Low half buffer
  localparam logic [7:0] OFS_HIGH_BUF = 8'h10; // High half buffer
  localparam logic [7:0] OFS_PULLUP = 8'h14; // Pull-up option

  // Field positions
  localparam int RT_LOW_BIT = 0; // Low half real-time enable
  localparam int RT_HIGH_BIT = 1; // High half real-time enable
  localparam int PULLUP_BIT = 0; // Port pull-up enable
  localparam int BE_LOW_LANE = 0; // Byte lane that carries every field

  // Reset values
  localparam logic [7:0] DIR_RESET = 8'hff; // All bits inputs
  localparam logic [7:0] LATCH_RESET = 8'h00; // Undefined, cleared here
  localparam logic [1:0] RT_CTRL_RESET = 2'h0; // Both halves plain port
  localparam logic [3:0] BUF_RESET = 4'h0; // Empty buffers
  localparam logic PULLUP_RESET = 1'b0; // Pull-ups off

  // Read answer for unmapped words
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage : pgro_pkg

// file: hw/pgro_port.sv
// Contract
// - Eight bits, direction chosen per bit
// - Reset makes all bits high-impedance inputs
// - Halves act as two nibbles or one byte
// - Control register picks port or real-time per half
// - Real-time half drives latch ignoring direction
// - Real-time half ignores latch writes, reads latch
// - Output latch holds until next write
// - Port read returns pin level for inputs
// - Port write updates every non-real-time latch bit
// - Inputs undriven; latch driven once switched output
// - Input-bit latch hidden behind pin level
// - Software pull-up shared across input pins
// - Pull-up only on input bits when enabled
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module pgro_port #(
  parameter int PORT_W = pgro_pkg::PORT_W, // Port width
  parameter int ADDR_W = pgro_pkg::ADDR_W // Bus address width
) (
  input wire logic clk_i, // 10 MHz system clock
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic [ADDR_W-1:0] address_i, // Avalon byte address
  input wire logic read_i, // Avalon read request
  input wire logic write_i, // Avalon write request
  input wire logic [3:0] byteenable_i, // Avalon byte enables
  input wire logic [31:0] writedata_i, // Avalon write data
  output logic [31:0] readdata_o, // Avalon read data, registered
  output logic waitrequest_o, // Avalon wait request
  input wire logic trigger_i, // Real-time output trigger pulse
  input wire logic [PORT_W-1:0] pin_i, // Pin levels, synchronous
  output logic [PORT_W-1:0] pin_o, // Value driven onto pins
  output logic [PORT_W-1:0] pin_oe_o, // Driver enable, high drives
  output logic [PORT_W-1:0] pullup_o // Pull-up connect per pin
);

  localparam int HALF_W = pgro_pkg::HALF_W; // Nibble width

  // Widen the two half enables into a per-pin mask
  function automatic logic [PORT_W-1:0] rt_mask(input logic [1:0] ctrl);
    logic [PORT_W-1:0] m;
    m = '0;
    for (int i = 0; i < PORT_W; i++) begin
      m[i] = (i < HALF_W) ? ctrl[pgro_pkg::RT_LOW_BIT]
                          : ctrl[pgro_pkg::RT_HIGH_BIT];
    end
    return m;
  endfunction : rt_mask

  // Stored state
  logic [PORT_W-1:0] latch_reg; // Output latch
  logic [PORT_W-1:0] direction_reg; // Port direction, 1 is input
  logic [1:0] rt_ctrl_reg; // Real-time enables, high and low
  logic [HALF_W-1:0] low_buf_reg; // Low half buffer
  logic [HALF_W-1:0] high_buf_reg; // High half buffer
  logic pullup_en_reg; // Port pull-up enable
  logic rd_done_reg; // Read answer ready this cycle
  logic [31:0] readdata_reg; // Captured read answer

  // Decoded strobes
  logic lane_ok; // Low byte lane enabled
  logic wr_data; // Write to the port data word
  logic wr_dir; // Write to the direction word
  logic wr_rt; // Write to the real-time control word
  logic wr_lbuf; // Write to the low buffer
  logic wr_hbuf; // Write to the high buffer
  logic wr_pull; // Write to the pull-up word
  logic [PORT_W-1:0] rt_bits; // Pins under real-time control
  logic [PORT_W-1:0] port_view; // What a port read sees
  logic [31:0] read_mux; // Selected read word

  assign rt_bits = rt_mask(rt_ctrl_reg);

  // Write decode, address chain
  always_comb begin
    lane_ok = byteenable_i[pgro_pkg::BE_LOW_LANE];
    wr_data = 1'b0;
    wr_dir = 1'b0;
    wr_rt = 1'b0;
    wr_lbuf = 1'b0;
    wr_hbuf = 1'b0;
    wr_pull = 1'b0;
    if (!(write_i && lane_ok)) begin
      // No write this cycle
    end else if (address_i == pgro_pkg::OFS_PORT_DATA) begin
      wr_data = 1'b1;
    end else if (address_i == pgro_pkg::OFS_DIRECTION) begin
      wr_dir = 1'b1;
    end else if (address_i == pgro_pkg::OFS_RT_CTRL) begin
      wr_rt = 1'b1;
    end else if (address_i == pgro_pkg::OFS_LOW_BUF) begin
      wr_lbuf = 1'b1;
    end else if (address_i == pgro_pkg::OFS_HIGH_BUF) begin
      wr_hbuf = 1'b1;
    end else if (address_i == pgro_pkg::OFS_PULLUP) begin
      wr_pull = 1'b1;
    end else begin
      // Unmapped writes are dropped
    end
  end

  // Port read view: pins for plain inputs, latch otherwise
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      // Real-time bits read their latch even with direction set
      port_view[i] = (direction_reg[i] && !rt_bits[i]) ? pin_i[i]
                                                       : latch_reg[i];
    end
  end

  // Output latch: writes, real-time lockout, trigger loads
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latch_reg <= pgro_pkg::LATCH_RESET;
    end else begin
      for (int i = 0; i < PORT_W; i++) begin
        if (rt_bits[i]) begin
          // Real-time bits change only on a trigger
          if (trigger_i) begin
            latch_reg[i] <= (i < HALF_W) ? low_buf_reg[i % HALF_W]
                                         : high_buf_reg[i % HALF_W];
          end
          // Software writes ignored here
        end else if (wr_data) begin
          // All plain bits take the write, inputs too
          latch_reg[i] <= writedata_i[i];
        end
        // Otherwise the value is held
      end
    end
  end

  // Direction register, inputs after reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      direction_reg <= pgro_pkg::DIR_RESET;
    end else if (wr_dir) begin
      direction_reg <= writedata_i[PORT_W-1:0];
    end
  end

  // Real-time control register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rt_ctrl_reg <= pgro_pkg::RT_CTRL_RESET;
    end else if (wr_rt) begin
      // Both bits set gives one byte-wide group
      rt_ctrl_reg <= {writedata_i[pgro_pkg::RT_HIGH_BIT],
                      writedata_i[pgro_pkg::RT_LOW_BIT]};
    end
  end

  // Buffer registers, loaded freely by software
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_buf_reg <= pgro_pkg::BUF_RESET;
      high_buf_reg <= pgro_pkg::BUF_RESET;
    end else begin
      if (wr_lbuf) begin
        low_buf_reg <= writedata_i[HALF_W-1:0];
      end
      if (wr_hbuf) begin
        high_buf_reg <= writedata_i[HALF_W-1:0];
      end
    end
  end

  // Pull-up option register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pullup_en_reg <= pgro_pkg::PULLUP_RESET;
    end else if (wr_pull) begin
      pullup_en_reg <= writedata_i[pgro_pkg::PULLUP_BIT];
    end
  end

  // Pin drive: real-time halves force drivers on
  always_comb begin
    pin_o = latch_reg; // Latch always presented, enables gate it
    pin_oe_o = rt_bits | ~direction_reg;
    // One enable bit serves the whole port
    pullup_o = pullup_en_reg ? direction_reg : '0;
  end

  // Read mux, address chain
  always_comb begin
    read_mux = pgro_pkg::UNMAPPED_READ;
    if (address_i == pgro_pkg::OFS_PORT_DATA) begin
      read_mux[PORT_W-1:0] = port_view;
    end else if (address_i == pgro_pkg::OFS_DIRECTION) begin
      read_mux[PORT_W-1:0] = direction_reg;
    end else if (address_i == pgro_pkg::OFS_RT_CTRL) begin
      read_mux[1:0] = rt_ctrl_reg;
    end else if (address_i == pgro_pkg::OFS_LOW_BUF) begin
      read_mux[HALF_W-1:0] = low_buf_reg;
    end else if (address_i == pgro_pkg::OFS_HIGH_BUF) begin
      read_mux[HALF_W-1:0] = high_buf_reg;
    end else if (address_i == pgro_pkg::OFS_PULLUP) begin
      read_mux[pgro_pkg::PULLUP_BIT] = pullup_en_reg;
    end else begin
      read_mux = pgro_pkg::UNMAPPED_READ;
    end
  end

  // Read handshake: one wait cycle so the answer comes from a flop
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_done_reg <= 1'b0;
      readdata_reg <= pgro_pkg::UNMAPPED_READ;
    end else if (read_i && !rd_done_reg) begin
      // Pin levels are sampled here, one cycle before the answer
      rd_done_reg <= 1'b1;
      readdata_reg <= read_mux;
    end else begin
      rd_done_reg <= 1'b0;
    end
  end

  // Writes finish at once; reads wait one cycle
  assign waitrequest_o = read_i && !rd_done_reg;
  assign readdata_o = readdata_reg;

  // Checks

  // Plain bits drive exactly when set as outputs
  oe_follows_dir_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ((pin_oe_o & ~rt_bits) == (~direction_reg & ~rt_bits)))
    else $error("Driver enable does not follow direction");

  // Real-time halves drive the latch no matter the direction
  rt_drive_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ((pin_oe_o & rt_bits) == rt_bits) && (pin_o == latch_reg))
    else $error("Real-time half is not driving its latch");

  // Software write leaves real-time bits alone without a trigger
  rt_write_lock_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_data && !trigger_i && (rt_bits != '0) && !wr_rt)
    |=> ((latch_reg & $past(rt_bits)) ==
         ($past(latch_reg) & $past(rt_bits))))
    else $error("Latch write reached a real-time bit");

  // Latch holds steady while nothing writes or triggers
  latch_hold_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (!wr_data && !trigger_i) [*2] |-> $stable(latch_reg))
    else $error("Output latch changed without a write");

  // A port write lands on inputs and outputs alike
  write_all_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_data && (rt_bits == '0))
    |=> (latch_reg == $past(writedata_i[PORT_W-1:0])))
    else $error("Port write missed some latch bits");

  // Port read answer carries pins for plain inputs
  read_pins_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (read_i && !rd_done_reg && (address_i == pgro_pkg::OFS_PORT_DATA))
    |=> !waitrequest_o &&
        (readdata_o[PORT_W-1:0] == $past(port_view)) &&
        ((readdata_o[PORT_W-1:0] & $past(direction_reg & ~rt_bits)) ==
         ($past(pin_i) & $past(direction_reg & ~rt_bits))))
    else $error("Port read did not return pin levels");

  // Pull-ups only on input pins and only when enabled
  pullup_sel_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (pullup_o == (pullup_en_reg ? direction_reg : '0)) &&
    ((pullup_o & pin_oe_o & ~rt_bits) == '0))
    else $error("Pull-up connected on a wrong pin");

  // Trigger loads both buffers when both halves run real-time
  trigger_load_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (trigger_i && (rt_ctrl_reg == 2'h3) && !wr_rt)
    |=> (latch_reg == $past({high_buf_reg, low_buf_reg})))
    else $error("Trigger did not copy the buffers");

  // Direction stays all-input until software writes it
  dir_reset_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ($past(direction_reg) == pgro_pkg::DIR_RESET) && !$past(wr_dir)
    |-> (direction_reg == pgro_pkg::DIR_RESET))
    else $error("Direction left all-input without a write");

  // Low half enable alone controls only the low nibble
  half_split_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (rt_ctrl_reg == 2'h1) |-> (rt_bits == {{HALF_W{1'b0}}, {HALF_W{1'b1}}}))
    else $error("Low half enable leaked into high half");

  // Read waits at most one cycle
  read_bound_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    read_i |-> ##[0:1] !waitrequest_o)
    else $error("Read answer took too long");

  // Trigger copies the low buffer into a real-time low half
  rt_low_load_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (trigger_i && rt_ctrl_reg[pgro_pkg::RT_LOW_BIT])
    |=> (latch_reg[HALF_W-1:0] == $past(low_buf_reg)))
    else $error("Low buffer did not reach the latch");

  // Trigger copies the high buffer into a real-time high half
  rt_high_load_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (trigger_i && rt_ctrl_reg[pgro_pkg::RT_HIGH_BIT])
    |=> (latch_reg[PORT_W-1:HALF_W] == $past(high_buf_reg)))
    else $error("High buffer did not reach the latch");

  // Trigger leaves plain bits alone; only writes move them
  plain_trigger_hold_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (trigger_i && !wr_data)
    |=> ((latch_reg & ~$past(rt_bits)) ==
         ($past(latch_reg) & ~$past(rt_bits))))
    else $error("Trigger disturbed a plain latch bit");

  // Real-time bits read back their latch, not the pins
  rt_read_latch_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (read_i && !rd_done_reg && (address_i == pgro_pkg::OFS_PORT_DATA))
    |=> ((readdata_o[PORT_W-1:0] & $past(rt_bits)) ==
         ($past(latch_reg) & $past(rt_bits))))
    else $error("Real-time bit read did not return its latch");

  // Direction word lands whole, one bit per pin
  dir_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_dir |=> (direction_reg == $past(writedata_i[PORT_W-1:0])))
    else $error("Direction write did not land");

  // Writes complete in the cycle they are offered
  write_nowait_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    write_i |-> !waitrequest_o)
    else $error("Write was held by wait request");

endmodule : pgro_port

// file: sim/pgro_pin_model.sv
`timescale 1ns/100ps
// Board side: resolves each pin from chip driver, load and pull-up
module pgro_pin_model (
  input wire logic clk_i, // System clock
  input wire logic [7:0] drv_i, // Chip output value
  input wire logic [7:0] drv_oe_i, // Chip drives when high
  input wire logic [7:0] pullup_i, // Chip pull-up connected
  input wire logic [7:0] load_oe_i, // Board load drives when high
  input wire logic [7:0] load_i, // Board load value
  output logic [7:0] level_o // Resolved pin level
);
  logic [7:0] float_reg = 8'h55; // Floating level, never stable

  // Toggle so an undriven pin cannot pass for a held value
  always_ff @(posedge clk_i) begin
    float_reg <= ~float_reg;
  end

  // Chip first, then load, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv_oe_i[i]) begin
        level_o[i] = drv_i[i];
      end else if (load_oe_i[i]) begin
        level_o[i] = load_i[i];
      end else if (pullup_i[i]) begin
        level_o[i] = 1'b1;
      end else begin
        level_o[i] = float_reg[i];
      end
    end
  end
endmodule : pgro_pin_model

// file: sim/tb_pgro_port.sv
`timescale 1ns/100ps
// Register-level bench for the port block
module tb_pgro_port;
  logic clk_i = 1'b0; // 10 MHz clock
  logic reset_n_i = 1'b0; // Reset, active low
  logic [7:0] address_i = 8'h00; // Bus address
  logic read_i = 1'b0; // Bus read
  logic write_i = 1'b0; // Bus write
  logic [3:0] byteenable_i = 4'h0; // Bus lanes
  logic [31:0] writedata_i = 32'h0; // Bus write data
  logic [31:0] readdata_o; // Bus read data
  logic waitrequest_o; // Bus stall
  logic trigger_i = 1'b0; // Real-time trigger
  logic [7:0] pin_i, pin_o, pin_oe_o, pullup_o; // Pin side
  logic [7:0] load_oe = 8'h00; // Board load enables
  logic [7:0] load_val = 8'h00; // Board load levels
  logic [31:0] rd_data; // Last read answer
  int fail_count = 0;
  int n_compared = 0;

  pgro_port dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .byteenable_i(byteenable_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .trigger_i(trigger_i), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pullup_o(pullup_o));
  pgro_pin_model board (.clk_i(clk_i), .drv_i(pin_o),
    .drv_oe_i(pin_oe_o), .pullup_i(pullup_o), .load_oe_i(load_oe),
    .load_i(load_val), .level_o(pin_i));

  // Clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // One bus cycle; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd, input logic [7:0] a,
      input logic [7:0] d, input logic [3:0] be);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    address_i <= a;
    read_i <= rd;
    write_i <= !rd;
    writedata_i <= {24'h0, d};
    byteenable_i <= be;
    // Only the watchdog ends a wait that never finishes
    while (!done) begin
      @(posedge clk_i);
      done = (waitrequest_o === 1'b0);
      if (done && rd) begin
        rd_data = readdata_o;
      end
    end
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 4'h1);
  endtask : wr

  // Pin-side result, looked at mid-cycle
  task automatic cmp_pin(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : cmp_pin

  // Register read result
  task automatic cmp_rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b1, a, 8'h00, 4'h1);
    n_compared++;
    if (rd_data !== exp) begin
      $display("CHECK FAILED read %h expected %h seen %h", a, exp, rd_data);
      fail_count++;
    end
  endtask : cmp_rd

  // One-cycle trigger pulse, result settled mid-cycle
  task automatic fire;
    @(posedge clk_i);
    trigger_i <= 1'b1;
    @(posedge clk_i);
    trigger_i <= 1'b0;
    @(negedge clk_i);
  endtask : fire

  task automatic summarize;
    $display("Compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // Hang guard at 2000 cycles, far beyond the fewer than one hundred cycles of the tests
  initial begin
    #200000;
    fail_count++;
    summarize();
  end

  // Whole-byte writes only, never read-modify-write
  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(negedge clk_i);
    cmp_pin("oe reset", 8'h00, pin_oe_o);
    cmp_pin("pullup reset", 8'h00, pullup_o);
    cmp_rd(pgro_pkg::OFS_DIRECTION, 32'hff);
    // Latch written while every bit is input
    wr(pgro_pkg::OFS_PORT_DATA, 8'ha5);
    load_oe <= 8'hff;
    load_val <= 8'h3c;
    @(negedge clk_i);
    cmp_pin("oe inputs", 8'h00, pin_oe_o);
    cmp_rd(pgro_pkg::OFS_PORT_DATA, 32'h3c);
    // Upper nibble to output, load keeps lower
    wr(pgro_pkg::OFS_DIRECTION, 8'h0f);
    load_oe <= 8'h0f;
    load_val <= 8'h06;
    @(negedge clk_i);
    cmp_pin("oe mixed", 8'hf0, pin_oe_o);
    cmp_pin("drive mixed", 8'ha0, pin_o & 8'hf0);
    cmp_rd(pgro_pkg::OFS_PORT_DATA, 32'ha6);
    // Pull-ups on inputs only; lane-0-less write dropped
    wr(pgro_pkg::OFS_PULLUP, 8'h01);
    bus(1'b0, pgro_pkg::OFS_PULLUP, 8'h00, 4'h2);
    @(negedge clk_i);
    cmp_pin("pullup on", 8'h0f, pullup_o);
    cmp_rd(pgro_pkg::OFS_PULLUP, 32'h1);
    wr(pgro_pkg::OFS_PULLUP, 8'h00);
    @(negedge clk_i);
    cmp_pin("pullup off", 8'h00, pullup_o);
    wr(8'h20, 8'hff);
    cmp_rd(8'h20, 32'h0);
    // Low half real-time; load released first
    load_oe <= 8'h00;
    wr(pgro_pkg::OFS_LOW_BUF, 8'h09);
    wr(pgro_pkg::OFS_HIGH_BUF, 8'h03);
    wr(pgro_pkg::OFS_RT_CTRL, 8'h01);
    @(negedge clk_i);
    cmp_pin("oe rt low", 8'hff, pin_oe_o);
    wr(pgro_pkg::OFS_PORT_DATA, 8'h00);
    cmp_rd(pgro_pkg::OFS_PORT_DATA, 32'h05);
    fire();
    cmp_pin("trigger low", 8'h09, pin_o);
    // Whole byte real-time over all-input direction
    wr(pgro_pkg::OFS_DIRECTION, 8'hff);
    wr(pgro_pkg::OFS_RT_CTRL, 8'h03);
    @(negedge clk_i);
    cmp_pin("oe rt byte", 8'hff, pin_oe_o);
    fire();
    cmp_pin("trigger byte", 8'h39, pin_o);
    wr(pgro_pkg::OFS_PORT_DATA, 8'h00);
    cmp_rd(pgro_pkg::OFS_PORT_DATA, 32'h39);
    cmp_rd(pgro_pkg::OFS_RT_CTRL, 32'h3);
    cmp_rd(pgro_pkg::OFS_LOW_BUF, 32'h9);
    cmp_rd(pgro_pkg::OFS_HIGH_BUF, 32'h3);
    wr(pgro_pkg::OFS_RT_CTRL, 8'h00);
    @(negedge clk_i);
    cmp_pin("oe rt off", 8'h00, pin_oe_o);
    summarize();
  end
endmodule : tb_pgro_port
